// *** hw/usu_core.sv ***
// Universal serial shift unit: shift register, edge counter and two-wire
// clock control. Assumes the CPU side runs on clk_i and the serial clock
// pin arrives as its own clock; pins are resolved outside the design.
//
// Operation
// [RQ1] Three-wire mode acts as SPI modes 0/1
// [RQ2] Eight clocks exchange both registers completely
// [RQ3] Serial clock shifts data and advances counter
// [RQ4] Master clocks by port or toggle strobe
// [RQ5] Edge select 0: sample rising, shift falling
// [RQ6] Edge select 1: sample falling, shift rising
// [RQ7] Both load byte before first sampling edge
// [RQ8] Count both edges, overflow after eight pulses
// [RQ9] Overflow can wake processor when enabled
// [RQ10] Strobe writes reach quarter system clock rate
// [RQ11] Two-wire physical bus, no filtering or slew
// [RQ12] Only slave uses clock hold logic; code holds the clock in any two-wire setup, master too
// [RQ13] Two-wire shifting on falling clock edge
// [RQ14] Master checks clock line actually rose
// [RQ15] Master starts by pulling data low
// [RQ16] Start detector sets start flag, may interrupt
// [RQ17] Start holds clock low until flag cleared
// [RQ18] Two-wire slave samples on rising edge
// [RQ19] Overflow after address byte holds clock low
// [RQ20] Acknowledging slave presets counter to fourteen
// [RQ21] Direction bit set means master read
// [RQ22] Withheld acknowledge ends transfer sequence
// [RQ23] Start flag clears on one, releases hold
// [RQ24] Overflow sets on wrap, clears on one
`timescale 1ns/100ps
`default_nettype none

module usu_core (
  // System clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Serial clock pin level, clocks the link-side capture
  input  wire logic              serial_clock_pin_i,
  // Serial data input pin (data line in two-wire mode)
  input  wire logic              serial_data_in_pin_i,
  // Configuration and CPU strobes
  input  wire usu_pkg::usu_ctrl_t ctrl_i,
  input  wire usu_pkg::usu_cpu_t  cpu_i,
  // Serial clock pin drive
  output logic                   serial_clock_pin_o,
  output logic                   serial_clock_pin_oe_n_o,
  // Three-wire data output pin
  output logic                   serial_data_out_o,
  output logic                   serial_data_out_oe_n_o,
  // Two-wire data line drive
  output logic                   serial_data_line_o,
  output logic                   serial_data_line_oe_n_o,
  // Status and event requests
  output usu_pkg::usu_status_t   status_o,
  output logic                   start_request_o,
  output logic                   overflow_wake_o
);

  // ---------------------------------------------------------------
  // Link side: capture data at each pin edge
  // ---------------------------------------------------------------
  // Each edge writes a two-slot ping-pong so a captured bit stays put for
  // two serial periods, long enough for the pointer to cross safely.
  logic [1:0] rise_slot;       // Bits captured on rising edges
  logic       rise_ptr;        // Toggles on each rising edge
  logic [1:0] next_rise_slot;  // Next rising capture
  logic       next_rise_ptr;   // Next rising pointer
  logic [1:0] fall_slot;       // Bits captured on falling edges
  logic       fall_ptr;        // Toggles on each falling edge
  logic [1:0] next_fall_slot;  // Next falling capture
  logic       next_fall_ptr;   // Next falling pointer

  // Next values for both edge captures
  always_comb begin
    next_rise_slot           = rise_slot;
    next_rise_slot[rise_ptr] = serial_data_in_pin_i;
    next_rise_ptr            = ~rise_ptr;
    next_fall_slot           = fall_slot;
    next_fall_slot[fall_ptr] = serial_data_in_pin_i;
    next_fall_ptr            = ~fall_ptr;
  end

  // Rising edge capture
  always_ff @(posedge serial_clock_pin_i or posedge rst_i) begin
    if (rst_i) begin
      rise_slot <= 2'h0;
      rise_ptr  <= 1'b0;
    end else begin
      rise_slot <= next_rise_slot;
      rise_ptr  <= next_rise_ptr;
    end
  end

  // Falling edge capture
  always_ff @(negedge serial_clock_pin_i or posedge rst_i) begin
    if (rst_i) begin
      fall_slot <= 2'h0;
      fall_ptr  <= 1'b0;
    end else begin
      fall_slot <= next_fall_slot;
      fall_ptr  <= next_fall_ptr;
    end
  end

  // ---------------------------------------------------------------
  // Crossing and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rise_sync;   // Rising pointer, two stages
  logic [1:0] fall_sync;   // Falling pointer, two stages
  logic [1:0] sda_sync;    // Data pin level, two stages
  logic [1:0] scl_sync;    // Clock pin level, two stages
  logic       rise_seen;   // Last rising pointer consumed
  logic       fall_seen;   // Last falling pointer consumed
  logic       sda_prev;    // Settled data level one cycle back
  logic       rise_evt;    // One rising edge arrived
  logic       fall_evt;    // One falling edge arrived
  logic       rise_bit;    // Bit captured at that rising edge
  logic       fall_bit;    // Bit captured at that falling edge

  // Only the second stage and later is read by logic
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_sync <= 2'h0;
      fall_sync <= 2'h0;
      sda_sync  <= 2'h3;
      scl_sync  <= 2'h3;
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
      sda_prev  <= 1'b1;
    end else begin
      rise_sync <= {rise_sync[0], rise_ptr};
      fall_sync <= {fall_sync[0], fall_ptr};
      sda_sync  <= {sda_sync[0], serial_data_in_pin_i};
      scl_sync  <= {scl_sync[0], serial_clock_pin_i};
      rise_seen <= rise_sync[1];
      fall_seen <= fall_sync[1];
      sda_prev  <= sda_sync[1];
    end
  end

  // Edge events and their bits; the slot read was filled before the toggle
  assign rise_evt = rise_sync[1] ^ rise_seen;
  assign fall_evt = fall_sync[1] ^ fall_seen;
  assign rise_bit = rise_slot[rise_seen];
  assign fall_bit = fall_slot[fall_seen];

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  logic two_wire;     // Two-wire mode active
  logic three_wire;   // Three-wire mode active
  logic ext_clk;      // Pin edges clock the unit
  logic sample_rise;  // Sample on rising, shift on falling
  logic sample_evt;   // Sampling edge this cycle
  logic shift_evt;    // Shifting edge this cycle
  logic sample_bit;   // Bit taken at the sampling edge

  assign two_wire   = ctrl_i.wire_mode[1];
  assign three_wire = (ctrl_i.wire_mode == usu_pkg::USU_WIRE_THREE);   // see [RQ1]
  assign ext_clk    = ctrl_i.external_clock_select;
  // Rising-edge shifting is useless on a two-wire bus, so it is forced off
  assign sample_rise = two_wire | ~ctrl_i.external_edge_select;     // see [RQ13]
  assign sample_evt  = sample_rise ? rise_evt : fall_evt;           // see [RQ5] [RQ6] [RQ18]
  assign shift_evt   = sample_rise ? fall_evt : rise_evt;           // see [RQ5] [RQ6]
  assign sample_bit  = sample_rise ? rise_bit : fall_bit;

  // ---------------------------------------------------------------
  // Counter step helper
  // ---------------------------------------------------------------
  // Returns the count plus the step, with the carry out in bit 4
  function automatic logic [4:0] count_add(input logic [3:0] cnt,
                                           input logic [1:0] step);
    count_add = {1'b0, cnt} + {3'h0, step};
  endfunction

  // ---------------------------------------------------------------
  // Shift register, latch, counter and flags
  // ---------------------------------------------------------------
  logic [7:0] shift_register;       // Serial shift register
  logic [7:0] next_shift_register;
  logic       held_bit;             // Bit sampled, awaiting shift
  logic       next_held_bit;
  logic       out_latch;            // Output latch on the MSB
  logic       next_out_latch;
  logic       latch_open;           // Latch transparent (first half)
  logic       next_latch_open;
  logic [3:0] count;                // Edge counter
  logic [3:0] next_count;
  logic       start_condition_flag; // Sticky start flag
  logic       next_start_flag;
  logic       counter_overflow_flag; // Sticky overflow flag
  logic       next_overflow_flag;
  logic       start_hold;           // Clock held after start
  logic       next_start_hold;
  logic       port_clk;             // Software clock pin port bit
  logic       next_port_clk;
  logic       overflow_wake;        // Registered wake request
  logic       next_overflow_wake;
  logic [1:0] step;                 // Counter step this cycle
  logic [4:0] sum;                  // Count plus step with carry
  logic       start_seen;           // Start condition this cycle

  // Start: data falls while clock stays high, two-wire only
  assign start_seen = two_wire & scl_sync[1] & sda_prev & ~sda_sync[1];

  // Counter advances once per strobe or pin edge; both pin edges count
  assign step = ext_clk ? {1'b0, rise_evt} + {1'b0, fall_evt}       // see [RQ8]
                        : {1'b0, cpu_i.software_clock_strobe};
  assign sum  = count_add(count, step);                             // see [RQ3]

  // Next values of the datapath and flags
  always_comb begin
    next_shift_register = shift_register;
    next_held_bit       = held_bit;
    next_latch_open     = latch_open;
    next_out_latch      = out_latch;
    next_count          = sum[3:0];
    next_start_flag     = start_condition_flag;
    next_overflow_flag  = counter_overflow_flag;
    next_start_hold     = start_hold;
    next_port_clk       = port_clk;
    // Shift register: a CPU load wins over a shift in the same cycle
    if (cpu_i.data_write) begin
      next_shift_register = cpu_i.data_value;                       // see [RQ7]
    end else if (ext_clk && shift_evt) begin
      next_shift_register = {shift_register[6:0], held_bit};        // see [RQ5] [RQ13]
    end else if (!ext_clk && cpu_i.software_clock_strobe) begin
      next_shift_register = {shift_register[6:0], sda_sync[1]};     // see [RQ10]
    end
    // Sampled bit waits for the opposite edge
    if (ext_clk && sample_evt) begin
      next_held_bit = sample_bit;                                   // see [RQ18]
    end
    // Latch opens at the shift edge, closes at the sample edge
    if (!ext_clk) begin
      next_latch_open = 1'b1;
    end else if (shift_evt) begin
      next_latch_open = 1'b1;
    end else if (sample_evt) begin
      next_latch_open = 1'b0;
    end
    if (next_latch_open) begin
      next_out_latch = next_shift_register[usu_pkg::MSB];
    end
    // Counter: CPU write wins, otherwise step
    if (cpu_i.count_write) begin
      next_count = cpu_i.count_value;
    end
    // Overflow: set on wrap wins over a write-one clear
    if (cpu_i.clear_overflow) begin
      next_overflow_flag = 1'b0;                                    // see [RQ24]
    end
    if (!cpu_i.count_write && sum[4]) begin
      next_overflow_flag = 1'b1;                                    // see [RQ24] [RQ2]
    end
    // Start flag: set wins over clear; clearing releases its hold
    if (cpu_i.clear_start) begin
      next_start_flag = 1'b0;                                       // see [RQ23]
      next_start_hold = 1'b0;
    end
    if (start_seen) begin
      next_start_flag = 1'b1;                                       // see [RQ16]
    end
    // Hold begins once the master has pulled the clock low after start
    if (two_wire && next_start_flag && !scl_sync[1]) begin
      next_start_hold = 1'b1;                                       // see [RQ17]
    end
    if (!two_wire) begin
      next_start_hold = 1'b0;
    end
    // Clock pin port bit: toggle strobe inverts, port write loads
    if (cpu_i.port_write) begin
      next_port_clk = cpu_i.port_value;                             // see [RQ4]
    end else if (cpu_i.clock_toggle_strobe) begin
      next_port_clk = ~port_clk;                                    // see [RQ4] [RQ10]
    end
    next_overflow_wake = next_overflow_flag & ctrl_i.overflow_int_enable; // see [RQ9]
  end

  // Register all datapath state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_register        <= usu_pkg::SHIFT_RST;
      held_bit              <= 1'b0;
      out_latch             <= 1'b0;
      latch_open            <= 1'b1;
      count                 <= usu_pkg::CNT_RST;
      start_condition_flag  <= 1'b0;
      counter_overflow_flag <= 1'b0;
      start_hold            <= 1'b0;
      port_clk              <= 1'b0;
      overflow_wake         <= 1'b0;
    end else begin
      shift_register        <= next_shift_register;
      held_bit              <= next_held_bit;
      out_latch             <= next_out_latch;
      latch_open            <= next_latch_open;
      count                 <= next_count;
      start_condition_flag  <= next_start_flag;
      counter_overflow_flag <= next_overflow_flag;
      start_hold            <= next_start_hold;
      port_clk              <= next_port_clk;
      overflow_wake         <= next_overflow_wake;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic clock_hold;  // Any two-wire setup stretches the clock low, master or slave

  // Any two-wire setup stretches, master or slave; either flag holds the clock low
  assign clock_hold = two_wire & (start_hold | counter_overflow_flag); // see [RQ12] [RQ19]

  // Clock pin: open drain in two-wire, push-pull in three-wire
  always_comb begin
    serial_clock_pin_o      = port_clk;
    serial_clock_pin_oe_n_o = ~ctrl_i.clock_dir_out;
    if (two_wire) begin
      serial_clock_pin_o      = 1'b0;                               // see [RQ11]
      serial_clock_pin_oe_n_o = ~(clock_hold | (ctrl_i.clock_dir_out & ~port_clk));
    end else if (!three_wire) begin
      serial_clock_pin_oe_n_o = 1'b1;
    end
  end

  // Data pins: DO in three-wire, open-drain data line in two-wire
  assign serial_data_out_o       = out_latch;
  assign serial_data_out_oe_n_o  = ~(three_wire & ctrl_i.data_dir_out); // see [RQ1]
  assign serial_data_line_o      = 1'b0;                           // see [RQ21] [RQ22]
  assign serial_data_line_oe_n_o = ~(two_wire & ctrl_i.data_dir_out & ~out_latch); // see [RQ11]

  // Status and requests
  assign status_o.shift_register        = shift_register;
  assign status_o.count                 = count;
  assign status_o.start_condition_flag  = start_condition_flag;
  assign status_o.counter_overflow_flag = counter_overflow_flag;
  assign status_o.data_collision        = two_wire & (out_latch ^ sda_sync[1]);
  assign start_request_o = start_condition_flag & ctrl_i.start_int_enable; // see [RQ16]
  assign overflow_wake_o = overflow_wake;                           // see [RQ9]

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Counter at its top value meets a clock edge with no CPU write
  sequence s_wrap;
    (count == usu_pkg::CNT_MAX) && (step != 2'h0) && !cpu_i.count_write;
  endsequence

  a_ovf_on_wrap: assert property (s_wrap |=> counter_overflow_flag && count < 4'h2) // see [RQ24]
    else $error("overflow flag missing after counter wrap");

  a_ovf_clear_only: assert property ($fell(counter_overflow_flag) |-> // see [RQ24]
    $past(cpu_i.clear_overflow))
    else $error("overflow flag fell without a clear");

  a_start_sets: assert property (start_seen |=> start_condition_flag) // see [RQ16]
    else $error("start condition not flagged");

  a_start_release: assert property ($fell(start_hold) |-> // see [RQ23]
    $past(cpu_i.clear_start) || !$past(two_wire))
    else $error("start hold released without flag clear");

  a_hold_clock_low: assert property (two_wire && counter_overflow_flag |-> // see [RQ19]
    !serial_clock_pin_oe_n_o && !serial_clock_pin_o)
    else $error("clock not held low on overflow");

  a_load_wins: assert property (cpu_i.data_write |=> // see [RQ7]
    shift_register == $past(cpu_i.data_value))
    else $error("shift register load lost");

  a_edge_shift: assert property (ext_clk && shift_evt && !cpu_i.data_write |=> // see [RQ5]
    shift_register == {$past(shift_register[6:0]), $past(held_bit)})
    else $error("shift edge did not shift");

  a_toggle_flip: assert property (cpu_i.clock_toggle_strobe && // see [RQ4]
    !cpu_i.port_write |=> port_clk != $past(port_clk))
    else $error("toggle strobe did not invert clock");

  a_wake_follow: assert property (counter_overflow_flag && // see [RQ9]
    ctrl_i.overflow_int_enable ##1 ctrl_i.overflow_int_enable && counter_overflow_flag |->
    overflow_wake_o)
    else $error("wake missing while overflow enabled");

  a_two_count: assert property (ext_clk && rise_evt && fall_evt && // see [RQ8]
    !cpu_i.count_write |=> count == $past(count) + 4'h2)
    else $error("both edges not counted");

endmodule

`default_nettype wire

// *** pkg/usu_pkg.sv ***
// Shared constants and carriers for the universal serial shift unit.
// Assumes a single system clock domain plus the serial clock pin domain.
package usu_pkg;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          DATA_W        = 8;      // Shift register width
  localparam int          CNT_W         = 4;      // Edge counter width
  localparam logic [7:0]  SHIFT_RST     = 8'h00;  // Shift register after reset
  localparam logic [3:0]  CNT_RST       = 4'h0;   // Counter after reset
  localparam logic [3:0]  CNT_MAX       = 4'hF;   // Last value before wrap
  localparam logic [3:0]  CNT_ACK_PRESET = 4'hE;  // Preset that stretches after one bit
  localparam int          MSB           = 7;      // Bit driven onto the data line

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          SYS_CLK_MHZ   = 25;     // System clock rate
  localparam int          SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;
  localparam int          FAST_DIV      = 4;      // Fastest strobe-driven serial clock ratio

  // ---------------------------------------------------------------
  // Wire modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    USU_WIRE_OFF   = 2'h0,  // Outputs disabled
    USU_WIRE_THREE = 2'h1,  // SPI modes 0 and 1
    USU_WIRE_TWO   = 2'h2,  // Two-wire bus
    USU_WIRE_TWO_H = 2'h3   // Two-wire, same behaviour
  } usu_wire_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    usu_wire_t   wire_mode;           // Wire mode select
    logic        external_clock_select; // 1: pin edges clock the unit
    logic        external_edge_select;  // 0: sample rising, 1: sample falling
    logic        start_int_enable;    // Start flag may request interrupt
    logic        overflow_int_enable; // Overflow flag may request interrupt
    logic        clock_dir_out;       // Clock pin direction is output
    logic        data_dir_out;        // Data pin direction is output
  } usu_ctrl_t;

  typedef struct packed {
    logic        data_write;          // Load shift register (pulse)
    logic [7:0]  data_value;          // Value to load
    logic        count_write;         // Load counter (pulse)
    logic [3:0]  count_value;         // Counter value to load
    logic        clear_start;         // Write-one clear of start flag (pulse)
    logic        clear_overflow;      // Write-one clear of overflow flag (pulse)
    logic        software_clock_strobe; // Internal clock strobe (pulse)
    logic        clock_toggle_strobe; // Invert clock pin port bit (pulse)
    logic        port_write;          // Write clock pin port bit (pulse)
    logic        port_value;          // Clock pin port bit value
  } usu_cpu_t;

  typedef struct packed {
    logic [7:0]  shift_register;      // Current shift register
    logic [3:0]  count;               // Current edge count
    logic        start_condition_flag;  // Start seen, sticky
    logic        counter_overflow_flag; // Counter wrapped, sticky
    logic        data_collision;      // Line differs from driven bit
  } usu_status_t;

endpackage

// *** sim/usu_peer.sv ***
// Peer serial master model: three-wire byte exchange and two-wire start.
// Assumes the bench resolves shared lines from its outputs.
`timescale 1ns/100ps
`default_nettype none
module usu_peer (
  // Line sense and drive
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      sdo_o
);
  localparam int SLOT_NS = 240;  // Long slots cover the unit's sync lag
  logic [7:0]    rx;             // Byte taken from the unit
  initial begin
    sck_o = 1'b0;
    sdo_o = 1'b1;
  end
  // Mode 0 master, clock idle low between frames
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      sdo_o = tx[i];
      #(SLOT_NS);
      rx = {rx[6:0], miso_i};
      sck_o = 1'b1;
      #(SLOT_NS);
      sck_o = 1'b0;
    end
    sdo_o = ~tx[0];  // Line no longer shows the last bit
  endtask
  // Data falls while clock high, then clock falls and is let go
  task automatic start2w();
    sck_o = 1'b1;
    sdo_o = 1'b1;
    #(SLOT_NS);
    sdo_o = 1'b0;
    #(SLOT_NS);
    sck_o = 1'b0;
    #(SLOT_NS);
    sck_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** sim/universal_serial_shift_unit_bench.sv ***
// Self-checking bench for the serial shift unit beside a peer master.
// Assumes open-drain lines read low when any party pulls them.
`timescale 1ns/100ps
`default_nettype none
module universal_serial_shift_unit_bench;
  // ----------------------------------------------------------------
  // Clock, wires and design
  // ----------------------------------------------------------------
  logic                 clk_i = 1'b0;  // System clock
  logic                 rst_i = 1'b1;  // Reset, held at start
  usu_pkg::usu_ctrl_t   ctrl = '0;     // Configuration levels
  usu_pkg::usu_cpu_t    cpu = '0;      // CPU strobes
  usu_pkg::usu_status_t st;            // Status seen
  logic sck, sdo, scl_w, sda_w, ck_o, ck_oe_n, do_o, do_oe_n, dl_o, dl_oe_n, s_req, wake;
  int                   error_cnt = 0; // Mismatches
  int                   checks = 0;    // Comparisons made
  always #20 clk_i = ~clk_i;
  assign scl_w = sck & (ck_oe_n | ck_o);
  assign sda_w = sdo & (dl_oe_n | dl_o);
  usu_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .serial_clock_pin_i(scl_w),
    .serial_data_in_pin_i(sda_w), .ctrl_i(ctrl), .cpu_i(cpu), .serial_clock_pin_o(ck_o),
    .serial_clock_pin_oe_n_o(ck_oe_n), .serial_data_out_o(do_o),
    .serial_data_out_oe_n_o(do_oe_n), .serial_data_line_o(dl_o),
    .serial_data_line_oe_n_o(dl_oe_n), .status_o(st), .start_request_o(s_req),
    .overflow_wake_o(wake));
  usu_peer u_peer (.miso_i(do_o), .sck_o(sck), .sdo_o(sdo));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One-cycle strobe, then a cycle for status to land
  task automatic drive(input usu_pkg::usu_cpu_t c);
    @(negedge clk_i) cpu = c;
    @(negedge clk_i) cpu = '0;
    @(negedge clk_i);
  endtask
  task automatic wait_ovf();
    int n;
    for (n = 0; n < 100 && st.counter_overflow_flag !== 1'b1; n++) @(negedge clk_i);
    if (n == 100) begin
      error_cnt++;
      $display("[FAIL] %0t no overflow", $time);
      finish_test();
    end
  endtask
  // Internal strobe, toggle strobe and the preset-14 wrap
  task automatic t_soft();
    usu_pkg::usu_cpu_t c;
    ctrl.wire_mode = usu_pkg::USU_WIRE_THREE;
    ctrl.clock_dir_out = 1'b1;
    c = '0;
    c.data_write = 1'b1;
    c.data_value = 8'hA5;
    drive(c);
    c = '0;
    c.software_clock_strobe = 1'b1;
    drive(c);
    cmp8(st.shift_register, 8'h4B);
    cmp8({4'h0, st.count}, 8'h01);
    c = '0;
    c.clock_toggle_strobe = 1'b1;
    drive(c);
    cmp1(ck_o, 1'b1);
    cmp1(ck_oe_n, 1'b0);
    drive(c);
    cmp1(ck_o, 1'b0);
    c = '0;
    c.count_write = 1'b1;
    c.count_value = usu_pkg::CNT_ACK_PRESET;
    drive(c);
    c = '0;
    c.software_clock_strobe = 1'b1;
    drive(c);
    cmp1(st.counter_overflow_flag, 1'b0);
    drive(c);
    cmp1(st.counter_overflow_flag, 1'b1);
    cmp8({4'h0, st.count}, 8'h00);
  endtask
  // Full byte exchange with the peer in edge mode 0
  task automatic t_spi();
    usu_pkg::usu_cpu_t c;
    ctrl.clock_dir_out = 1'b0;
    ctrl.external_clock_select = 1'b1;
    ctrl.data_dir_out = 1'b1;
    ctrl.overflow_int_enable = 1'b1;
    c = '0;
    c.clear_overflow = 1'b1;
    c.count_write = 1'b1;
    drive(c);
    cmp1(st.counter_overflow_flag, 1'b0);
    c = '0;
    c.data_write = 1'b1;
    c.data_value = 8'h3C;
    drive(c);
    u_peer.xfer(8'hC5);
    wait_ovf();
    @(negedge clk_i);
    cmp8(st.shift_register, 8'hC5);
    cmp8(u_peer.rx, 8'h3C);
    cmp8({4'h0, st.count}, 8'h00);
    cmp1(wake, 1'b1);
  endtask
  // Two-wire start sets the flag and holds the clock until cleared
  task automatic t_start();
    usu_pkg::usu_cpu_t c;
    ctrl = '0;
    ctrl.wire_mode = usu_pkg::USU_WIRE_TWO;
    ctrl.external_clock_select = 1'b1;
    ctrl.start_int_enable = 1'b1;
    // Overflow left from the byte exchange still holds the clock low
    @(negedge clk_i);
    cmp1(ck_oe_n, 1'b0);
    c = '0;
    c.clear_overflow = 1'b1;
    c.count_write = 1'b1;
    drive(c);
    cmp1(ck_oe_n, 1'b1);
    u_peer.start2w();
    repeat (10) @(negedge clk_i);
    cmp1(st.start_condition_flag, 1'b1);
    cmp1(s_req, 1'b1);
    cmp1(scl_w, 1'b0);
    c = '0;
    c.clear_start = 1'b1;
    c.count_write = 1'b1;
    drive(c);
    cmp1(st.start_condition_flag, 1'b0);
    cmp1(ck_oe_n, 1'b1);
    cmp1(scl_w, 1'b1);
    // Software clock keeps the output latch open for direct loads
    ctrl.external_clock_select = 1'b0;
    ctrl.data_dir_out = 1'b1;
    c = '0;
    c.data_write = 1'b1;
    c.data_value = 8'h80;
    drive(c);
    cmp1(dl_oe_n, 1'b1);
    cmp1(st.data_collision, 1'b1);
    c.data_value = 8'h00;
    drive(c);
    cmp1(dl_oe_n, 1'b0);
    cmp1(st.data_collision, 1'b0);
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    cmp8(st.shift_register, usu_pkg::SHIFT_RST);
    cmp1(st.counter_overflow_flag, 1'b0);
    cmp1(do_oe_n, 1'b1);
    repeat (3) @(negedge clk_i);
    t_soft();
    t_spi();
    t_start();
    finish_test();
  end
endmodule
`default_nettype wire
